// ---- rtl/flash_erase_pkg.sv ----
// Package: register map, field layout, reset values and counts of the flash controller
package flash_erase_pkg;
    // Register byte offsets on the bus
    localparam logic [3:0] ctrl_off = 4'h0;
    localparam logic [3:0] clock_off = 4'h4;
    localparam logic [3:0] status_off = 4'h8;
    // Mode register bits
    localparam int ctl_erase_bit = 0;
    localparam int ctl_mass_bit = 1;
    localparam int ctl_prog_bit = 6;
    localparam int ctl_block_bit = 7;
    // Clock register bits
    localparam int clk_src_bit = 0;
    localparam int clk_div_lsb = 1;
    localparam int div_w = 6;
    // Status register bits
    localparam int st_busy_bit = 0;
    localparam int st_lock_bit = 1;
    localparam int st_viol_bit = 2;
    localparam int st_infolock_bit = 3;
    // Values after reset
    localparam logic reset_general_lock = 1'b1;
    localparam logic reset_info_lock = 1'b1;
    localparam logic [div_w-1:0] reset_divider = 6'h00;
    // Array geometry: 16-bit words, 1KB segments, segment 0 is info
    localparam int word_w = 16;
    localparam int waddr_w = 11;
    localparam int baddr_w = 12;
    localparam int seg_lsb = 10;
    localparam logic [1:0] info_seg = 2'h0;
    localparam logic [1:0] last_seg = 2'h2;
    localparam logic [waddr_w-1:0] info_first = 11'h000;
    localparam logic [waddr_w-1:0] main_first = 11'h200;
    localparam logic [waddr_w-1:0] flash_last = 11'h5FF;
    localparam logic [waddr_w-1:0] seg_words_m1 = 11'h1FF;
    localparam logic [word_w-1:0] erased_word = 16'hFFFF;
    // Timing generator cycles
    localparam int ftg_w = 16;
    localparam logic [ftg_w-1:0] prog_ftg_cycles = 16'h001E;
    localparam int erase_ftg_default = 5000;
    typedef enum logic [1:0] {
        st_read = 2'b00,
        st_prog = 2'b01,
        st_erase = 2'b11
    } op_state_type;
endpackage

// ---- rtl/flash_erase_controller.sv ----
// Flash controller: mode registers, erase/program sequencing and array
`timescale 1ns/1ps
// How it works
// [R1] Read mode: generators off, array reads plainly
// [R2] Byte and word reads and programs supported
// [R3] Info and main handled identically except address
// [R4] Segment of 1KB is the erase unit
// [R5] Info lock set blocks info program and erase
// [R6] Info lock clear: info treated like main
// [R7] Writing one toggles info lock, zero nothing
// [R8] Mode decoded from three control bits; the block write bit has no effect
// [R9] Erase bits pick segment, main, or all
// [R10] Erase sets ones; programming only clears bits
// [R11] Dummy write in range starts erase cycle
// [R12] Busy set from dummy write through cycle
// [R13] Cycle end clears busy and erase bits
// [R14] Out-of-range dummy write is silently ignored
// [R15] Erase duration fixed, independent of size; the end also waits for the range walker
// [R16] Start from flash holds CPU until done
// [R17] Start from RAM leaves CPU running
// [R18] Flash access while busy sets violation flag
// [R19] RAM software polls busy before flash access
// [R20] CPU avoids array during program or erase
// [R21] Timing clock: source select plus divider
// [R22] Software keeps timing clock in range
// [R23] Program bits select word or block write; block_write_select is stored but never used
// [R24] Erase length is a tick-count parameter
// [R25] General lock makes erase writes ignored
// [R26] Busy keeps the selected clock source requested
module flash_erase_controller #(
    parameter int erase_ftg_cycles = flash_erase_pkg::erase_ftg_default
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic main_clk_en,
    input wire logic subsystem_clk_en,
    input wire logic flash_req,
    input wire logic flash_we,
    input wire logic [1:0] flash_be,
    input wire logic [flash_erase_pkg::baddr_w-1:0] flash_addr,
    input wire logic [flash_erase_pkg::word_w-1:0] flash_wdata,
    input wire logic flash_from_ram,
    output logic [flash_erase_pkg::word_w-1:0] flash_rdata,
    output logic flash_ack,
    output logic cpu_hold,
    output logic busy,
    output logic timing_gen_on,
    output logic voltage_gen_on,
    output logic clock_keep_request
);
    localparam int dw = flash_erase_pkg::div_w;
    localparam int aw = flash_erase_pkg::waddr_w;
    localparam int fw = flash_erase_pkg::ftg_w;
    localparam int ww = flash_erase_pkg::word_w;
    localparam logic [fw-1:0] erase_ticks = fw'(erase_ftg_cycles);

    typedef struct packed {
        flash_erase_pkg::op_state_type op;

        logic erase;
        logic mass_erase_select;
        logic program_enable;
        logic block_write_select;

        logic clk_src;
        logic [dw-1:0] timing_clock_divider;

        logic general_lock;
        logic info_segment_lock;
        logic access_violation_flag;

        logic [dw-1:0] div_cnt;
        logic [fw-1:0] ftg_cnt;
        logic [fw-1:0] ftg_target;

        logic [aw-1:0] walk_ptr;
        logic [aw-1:0] walk_end;
        logic walk_done;

        logic dphase_wr;
        logic [3:0] dphase_off;
        logic [31:0] hrdata;
        logic hreadyout;

        logic flash_ack;
        logic cpu_hold;
        logic timing_gen_on;
        logic voltage_gen_on;
    } state_type;

    state_type state_r;
    state_type state_nxt;

    logic [ww-1:0] mem [0:flash_erase_pkg::flash_last];
    logic [ww-1:0] rdata_r;

    logic mem_we;
    logic [aw-1:0] mem_waddr;
    logic [ww-1:0] mem_wdata;

    logic [ww-1:0] cur_word;
    logic [1:0] req_seg;
    logic [aw-1:0] req_word;
    logic req_mapped;
    logic req_info;

    logic src_pulse;
    logic ftg_tick;

    logic [31:0] wr;

    assign req_seg = flash_addr[flash_erase_pkg::seg_lsb +: 2];
    assign req_word = aw'(flash_addr[flash_erase_pkg::baddr_w-1:1]);
    assign req_mapped = req_seg <= flash_erase_pkg::last_seg;
    assign req_info = req_seg == flash_erase_pkg::info_seg;
    assign cur_word = mem[req_word];
    assign wr = hwdata;

    always_comb begin
        state_nxt = state_r;
        mem_we = 1'b0;
        mem_waddr = state_r.walk_ptr;
        mem_wdata = flash_erase_pkg::erased_word;
        src_pulse = state_r.clk_src ? subsystem_clk_en : main_clk_en;
        ftg_tick = 1'b0;

        state_nxt.flash_ack = 1'b0;
        state_nxt.hreadyout = 1'b1;

        // Divider runs only while an operation is active; see [R1] [R21]
        if (state_r.op != flash_erase_pkg::st_read && src_pulse) begin
            if (state_r.div_cnt == state_r.timing_clock_divider) begin
                state_nxt.div_cnt = '0;
                ftg_tick = 1'b1;
            end else begin
                state_nxt.div_cnt = state_r.div_cnt + 1'b1;
            end
        end

        if (ftg_tick && state_r.ftg_cnt != state_r.ftg_target) begin
            state_nxt.ftg_cnt = state_r.ftg_cnt + 1'b1;
        end

        // Erase walker sets each word of the range to ones; see [R10] [R4]
        if (state_r.op == flash_erase_pkg::st_erase && !state_r.walk_done) begin
            mem_we = 1'b1;
            if (state_r.walk_ptr == state_r.walk_end) begin
                state_nxt.walk_done = 1'b1;
            end else begin
                state_nxt.walk_ptr = state_r.walk_ptr + 1'b1;
            end
        end

        // Length set by tick count and, for erase, by the walker finishing too; see [R15] [R24]
        if (state_r.op != flash_erase_pkg::st_read
                && state_r.ftg_cnt == state_r.ftg_target
                && (state_r.walk_done || state_r.op == flash_erase_pkg::st_prog)) begin
            state_nxt.op = flash_erase_pkg::st_read;
            state_nxt.cpu_hold = 1'b0;
            state_nxt.timing_gen_on = 1'b0;
            state_nxt.voltage_gen_on = 1'b0;
            if (state_r.op == flash_erase_pkg::st_erase) begin
                state_nxt.erase = 1'b0; // see [R13]
                state_nxt.mass_erase_select = 1'b0;
            end
        end

        // CPU side of the array
        if (flash_req) begin
            state_nxt.flash_ack = 1'b1;
            if (state_r.op != flash_erase_pkg::st_read) begin
                // Writes refused while busy, reads still return array data; see [R18]
                state_nxt.access_violation_flag = 1'b1;
            end else if (flash_we && req_mapped
                    && !state_r.general_lock) begin // see [R25]
                // Mode decode from the erase, mass and program bits; see [R8] [R9] [R23]
                if (state_r.erase || state_r.mass_erase_select) begin
                    if (!state_r.mass_erase_select) begin
                        // Segment erase, any segment alike; see [R3] [R5] [R6]
                        if (!(req_info && state_r.info_segment_lock)) begin
                            state_nxt.op = flash_erase_pkg::st_erase;
                            state_nxt.walk_ptr = {req_seg, 9'h000};
                            state_nxt.walk_end = {req_seg, 9'h000}
                                | flash_erase_pkg::seg_words_m1;
                        end
                    end else if (!req_info) begin
                        // Mass or all erase, started from main; see [R14]
                        state_nxt.op = flash_erase_pkg::st_erase;
                        state_nxt.walk_ptr = flash_erase_pkg::main_first;
                        if (state_r.erase && !state_r.info_segment_lock) begin
                            state_nxt.walk_ptr = flash_erase_pkg::info_first; // see [R9]
                        end
                        state_nxt.walk_end = flash_erase_pkg::flash_last;
                    end else if (state_r.erase && !state_r.info_segment_lock) begin
                        state_nxt.op = flash_erase_pkg::st_erase;
                        state_nxt.walk_ptr = flash_erase_pkg::info_first;
                        state_nxt.walk_end = flash_erase_pkg::flash_last;
                    end
                    if (state_nxt.op == flash_erase_pkg::st_erase) begin
                        // Dummy write launches the cycle; see [R11] [R12]
                        state_nxt.ftg_target = erase_ticks;
                        state_nxt.walk_done = 1'b0;
                    end
                end else if (state_r.program_enable
                        && !(req_info && state_r.info_segment_lock)) begin
                    // Byte or word program clears bits only; see [R2] [R10]
                    mem_we = 1'b1;
                    mem_waddr = req_word;
                    mem_wdata = cur_word & {flash_be[1] ? flash_wdata[15:8]
                        : 8'hFF, flash_be[0] ? flash_wdata[7:0] : 8'hFF};
                    state_nxt.op = flash_erase_pkg::st_prog;
                    state_nxt.ftg_target = flash_erase_pkg::prog_ftg_cycles;
                end
                if (state_nxt.op != flash_erase_pkg::st_read) begin
                    state_nxt.ftg_cnt = '0;
                    state_nxt.div_cnt = '0;
                    state_nxt.timing_gen_on = 1'b1;
                    state_nxt.voltage_gen_on = 1'b1;
                    // Hold only code running from flash; see [R16] [R17]
                    state_nxt.cpu_hold = !flash_from_ram;
                end
            end
        end

        // Bus data phase write
        if (state_r.dphase_wr) begin
            unique case (state_r.dphase_off)
                flash_erase_pkg::ctrl_off: begin
                    if (state_r.op == flash_erase_pkg::st_read) begin
                        state_nxt.erase = wr[flash_erase_pkg::ctl_erase_bit];
                        state_nxt.mass_erase_select =
                            wr[flash_erase_pkg::ctl_mass_bit];
                        state_nxt.program_enable =
                            wr[flash_erase_pkg::ctl_prog_bit];
                        state_nxt.block_write_select =
                            wr[flash_erase_pkg::ctl_block_bit];
                    end
                end

                flash_erase_pkg::clock_off: begin
                    // Frozen while busy so the tick rate holds steady
                    if (state_r.op == flash_erase_pkg::st_read) begin
                        state_nxt.clk_src = wr[flash_erase_pkg::clk_src_bit];
                        state_nxt.timing_clock_divider =
                            wr[flash_erase_pkg::clk_div_lsb +: dw];
                    end
                end

                flash_erase_pkg::status_off: begin
                    state_nxt.general_lock = wr[flash_erase_pkg::st_lock_bit];
                    if (wr[flash_erase_pkg::st_infolock_bit]) begin
                        state_nxt.info_segment_lock = !state_r.info_segment_lock; // see [R7]
                    end
                    // Write one clears; a new violation in this cycle wins
                    if (wr[flash_erase_pkg::st_viol_bit] && !(flash_req
                            && state_r.op != flash_erase_pkg::st_read)) begin
                        state_nxt.access_violation_flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Bus address phase; zero wait states, read data prepared here
        state_nxt.dphase_wr = 1'b0;
        if (hsel && htrans[1] && hready) begin
            state_nxt.dphase_wr = hwrite;
            state_nxt.dphase_off = haddr[3:0];
            state_nxt.hrdata = 32'h0000_0000;
            unique case (haddr[3:0])
                flash_erase_pkg::ctrl_off: begin
                    state_nxt.hrdata[flash_erase_pkg::ctl_erase_bit] =
                        state_nxt.erase;
                    state_nxt.hrdata[flash_erase_pkg::ctl_mass_bit] =
                        state_nxt.mass_erase_select;
                    state_nxt.hrdata[flash_erase_pkg::ctl_prog_bit] =
                        state_r.program_enable;
                    state_nxt.hrdata[flash_erase_pkg::ctl_block_bit] =
                        state_r.block_write_select;
                end

                flash_erase_pkg::clock_off: begin
                    state_nxt.hrdata[flash_erase_pkg::clk_src_bit] =
                        state_r.clk_src;
                    state_nxt.hrdata[flash_erase_pkg::clk_div_lsb +: dw] =
                        state_r.timing_clock_divider;
                end

                flash_erase_pkg::status_off: begin
                    state_nxt.hrdata[flash_erase_pkg::st_busy_bit] =
                        state_nxt.op != flash_erase_pkg::st_read;
                    state_nxt.hrdata[flash_erase_pkg::st_lock_bit] =
                        state_r.general_lock;
                    state_nxt.hrdata[flash_erase_pkg::st_viol_bit] =
                        state_r.access_violation_flag;
                    state_nxt.hrdata[flash_erase_pkg::st_infolock_bit] =
                        state_r.info_segment_lock;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= '0;

            state_r.op <= flash_erase_pkg::st_read;
            state_r.general_lock <= flash_erase_pkg::reset_general_lock;
            state_r.info_segment_lock <= flash_erase_pkg::reset_info_lock;
            state_r.timing_clock_divider <= flash_erase_pkg::reset_divider;
            state_r.walk_done <= 1'b1;
            state_r.hreadyout <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Array contents survive reset, as real flash does
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    // Plain reads straight from the array; see [R1]
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= flash_erase_pkg::erased_word;
        end else if (flash_req && !flash_we) begin
            rdata_r <= cur_word;
        end
    end

    // Bus outputs
    assign hrdata = state_r.hrdata;

    assign hreadyout = state_r.hreadyout;

    assign hresp = 1'b0;

    // CPU side outputs
    assign flash_rdata = rdata_r;

    assign flash_ack = state_r.flash_ack;

    assign cpu_hold = state_r.cpu_hold;

    // Generator flop is set and cleared exactly with the operation
    assign busy = state_r.timing_gen_on; // see [R12]

    assign timing_gen_on = state_r.timing_gen_on;

    assign voltage_gen_on = state_r.voltage_gen_on;

    assign clock_keep_request = state_r.timing_gen_on; // see [R26]
endmodule

// ---- verif/flash_erase_monitor.sv ----
// Checker of the flash controller's CPU-side port relations
`timescale 1ns/1ps
module flash_erase_monitor #(
    parameter int erase_ftg_cycles = 5000
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic flash_req,
    input wire logic flash_we,
    input wire logic flash_from_ram,
    input wire logic flash_ack,
    input wire logic cpu_hold,
    input wire logic busy,
    input wire logic timing_gen_on,
    input wire logic voltage_gen_on,
    input wire logic clock_keep_request
);
    // Loose ceiling: walker plus slowest tick rate, full divider on the 3-cycle subsystem clock
    localparam int lim = 1600 + 192 * (erase_ftg_cycles + 30);
    int cnt_r;
    int cnt_nxt;
    always_comb cnt_nxt = busy ? cnt_r + 1 : 0;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) cnt_r <= 0;
        else cnt_r <= cnt_nxt;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_launch; $rose(busy); endsequence
    sequence s_run; busy [*8]; endsequence
    // Two idle cycles so a one-cycle lag of the flops is tolerated
    property p_gen_off;
        !busy [*2] |-> !timing_gen_on && !voltage_gen_on;
    endproperty
    property p_start;
        s_launch |-> $past(flash_req && flash_we) && timing_gen_on;
    endproperty
    property p_hold; $rose(busy) && !$past(flash_from_ram) |-> cpu_hold;
    endproperty
    property p_ram; $rose(busy) && $past(flash_from_ram) |-> !cpu_hold [*8];
    endproperty
    property p_keep; busy |-> clock_keep_request; endproperty
    property p_hold_busy; cpu_hold |-> busy; endproperty
    property p_min; s_launch |-> s_run; endproperty
    property p_max; cnt_r < lim; endproperty
    property p_end; $fell(busy) |-> !cpu_hold && !timing_gen_on; endproperty
    property p_ack; flash_req |=> flash_ack; endproperty
    a_gen_off: assert property (p_gen_off) else $error("gen on");
    a_start: assert property (p_start) else $error("bad start");
    a_hold: assert property (p_hold) else $error("not held");
    a_ram: assert property (p_ram) else $error("ram held");
    a_keep: assert property (p_keep) else $error("no keep");
    a_hold_busy: assert property (p_hold_busy) else $error("hold");
    a_min: assert property (p_min) else $error("busy short");
    a_max: assert property (p_max) else $error("busy long");
    a_end: assert property (p_end) else $error("end state");
    a_ack: assert property (p_ack) else $error("no ack");
endmodule

bind flash_erase_controller flash_erase_monitor #(
    .erase_ftg_cycles(erase_ftg_cycles)
) u_mon (
    .clk(clk), .rst_b(rst_b), .flash_req(flash_req), .flash_we(flash_we),
    .flash_from_ram(flash_from_ram), .flash_ack(flash_ack),
    .cpu_hold(cpu_hold), .busy(busy), .timing_gen_on(timing_gen_on),
    .voltage_gen_on(voltage_gen_on), .clock_keep_request(clock_keep_request)
);

// ---- verif/flash_cpu_model.sv ----
// Behavioural CPU issuing flash reads, programs and dummy writes
`timescale 1ns/1ps
module flash_cpu_model (
    input wire logic clk,
    input wire logic [15:0] flash_rdata,
    input wire logic flash_ack,
    input wire logic cpu_hold,
    input wire logic busy,
    output logic flash_req,
    output logic flash_we,
    output logic [1:0] flash_be,
    output logic [11:0] flash_addr,
    output logic [15:0] flash_wdata,
    output logic flash_from_ram
);
    initial begin
        flash_req = 1'b0;
        flash_we = 1'b0;
        flash_be = 2'h0;
        flash_addr = 12'h000;
        flash_wdata = 16'h0000;
        flash_from_ram = 1'b1;
    end
    task automatic access(input logic we, input logic [11:0] a,
            input logic [1:0] be, input logic [15:0] d, input logic ram,
            input logic rude, output logic [15:0] q, output logic ok);
        int n = 0;
        // Waits out busy unless told to misbehave
        while (busy === 1'b1 && !rude && n < 4000) begin
            @(posedge clk);
            n++;
        end
        flash_req <= 1'b1;
        flash_we <= we;
        flash_be <= be;
        flash_addr <= a;
        flash_wdata <= d;
        flash_from_ram <= ram;
        @(posedge clk);
        // Released byte enables, address and data carry the inverse; we and ram stay stale
        flash_req <= 1'b0;
        flash_be <= ~be;
        flash_addr <= ~a;
        flash_wdata <= ~d;
        @(posedge clk);
        ok = flash_ack === 1'b1;
        q = flash_rdata;
        // A stalled CPU issues nothing until released
        while (cpu_hold === 1'b1 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        ok = ok && n < 4000;
    endtask
endmodule

// ---- verif/tb_flash_erase_controller.sv ----
// Self-checking bench of the flash controller
`timescale 1ns/1ps
module tb_flash_erase_controller;
    localparam logic [3:0] ct = flash_erase_pkg::ctrl_off;
    localparam logic [3:0] ck = flash_erase_pkg::clock_off;
    localparam logic [3:0] st = flash_erase_pkg::status_off;
    logic clk, rst_b, hsel, hwrite, hreadyout, hresp, rude;
    logic main_clk_en, subsystem_clk_en, flash_req, flash_we, flash_ack;
    logic flash_from_ram, cpu_hold, busy, timing_gen_on, voltage_gen_on;
    logic clock_keep_request;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, flash_be, ph;
    logic [11:0] flash_addr;
    logic [15:0] flash_wdata, flash_rdata, fq;
    int error_cnt = 0;
    int compares = 0;
    flash_erase_controller #(.erase_ftg_cycles(4)) u_flash_erase_controller (
        .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .main_clk_en(main_clk_en),
        .subsystem_clk_en(subsystem_clk_en), .flash_req(flash_req),
        .flash_we(flash_we), .flash_be(flash_be), .flash_addr(flash_addr),
        .flash_wdata(flash_wdata), .flash_from_ram(flash_from_ram),
        .flash_rdata(flash_rdata), .flash_ack(flash_ack),
        .cpu_hold(cpu_hold), .busy(busy), .timing_gen_on(timing_gen_on),
        .voltage_gen_on(voltage_gen_on),
        .clock_keep_request(clock_keep_request));
    flash_cpu_model cpu (
        .clk(clk), .flash_rdata(flash_rdata), .flash_ack(flash_ack),
        .cpu_hold(cpu_hold), .busy(busy), .flash_req(flash_req),
        .flash_we(flash_we), .flash_be(flash_be), .flash_addr(flash_addr),
        .flash_wdata(flash_wdata), .flash_from_ram(flash_from_ram));
    always #2.5 clk = ~clk;
    // Main edge every 2 cycles, subsystem every 3
    always @(posedge clk) begin
        main_clk_en <= ~main_clk_en;
        ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
        subsystem_clk_en <= (ph == 2'h2);
    end
    task automatic end_sim();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a,
            input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        hsel <= 1'b1;
        haddr <= {28'h0000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
        q = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
        if (n >= 50) begin error_cnt++; end_sim(); end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input string nm, input logic [3:0] a, logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(nm, q, e);
    endtask
    task automatic fl(input logic we, input logic [11:0] a,
            input logic [15:0] d, input logic [1:0] be, input logic ram);
        logic ok;
        cpu.access(we, a, be, d, ram, rude, fq, ok);
        check("flash ack", {31'h0, ok}, 32'h1);
    endtask
    task automatic fr(input logic [11:0] a, input logic [15:0] e);
        fl(1'b0, a, 16'h0000, 2'h3, 1'b1);
        check("flash word", {16'h0, fq}, {16'h0, e});
    endtask
    task automatic wait_idle();
        logic [31:0] q;
        int n = 0;
        do begin bus(1'b0, st, 32'h0, q); n++; end
        while (q[0] !== 1'b0 && n < 2000);
        if (n >= 2000) begin error_cnt++; end_sim(); end
    endtask
    initial begin
        {clk, rst_b, hsel, hwrite, rude, main_clk_en, subsystem_clk_en} = 0;
        {haddr, hwdata, htrans, ph} = 0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd("ctrl", ct, 32'h0);
        rd("clock", ck, 32'h0);
        rd("status", st, 32'hA);
        rd("unmapped", 4'hC, 32'h0);
        wr(ct, 32'h1);
        fl(1'b1, 12'h400, 16'h0000, 2'h3, 1'b1);
        rd("status", st, 32'hA);
        wr(st, 32'h8);
        rd("status", st, 32'h0);
        wr(st, 32'h0);
        rd("status", st, 32'h0);
        wr(ck, 32'h3);
        rd("clock", ck, 32'h3);
        wr(ct, 32'h3);
        fl(1'b1, 12'h400, 16'h0000, 2'h3, 1'b1);
        rd("status", st, 32'h1);
        wr(ck, 32'h0);
        rd("clock", ck, 32'h3);
        wait_idle();
        rd("ctrl", ct, 32'h0);
        fr(12'h400, 16'hFFFF);
        fr(12'h010, 16'hFFFF);
        wr(ct, 32'h40);
        fl(1'b1, 12'h400, 16'h1234, 2'h3, 1'b0);
        fl(1'b1, 12'h400, 16'h0F0F, 2'h1, 1'b0);
        fl(1'b1, 12'h010, 16'h5555, 2'h3, 1'b0);
        fr(12'h400, 16'h1204);
        fr(12'h010, 16'h5555);
        wr(ct, 32'hC0);
        fl(1'b1, 12'h402, 16'hA5A5, 2'h3, 1'b1);
        fr(12'h402, 16'hA5A5);
        wr(st, 32'h8);
        wr(ct, 32'h40);
        fl(1'b1, 12'h010, 16'h0000, 2'h3, 1'b0);
        fr(12'h010, 16'h5555);
        wr(ct, 32'h3);
        fl(1'b1, 12'h400, 16'h0000, 2'h3, 1'b0);
        fr(12'h400, 16'hFFFF);
        fr(12'h010, 16'h5555);
        wr(st, 32'h8);
        wr(ct, 32'h40);
        fl(1'b1, 12'h400, 16'h0000, 2'h3, 1'b0);
        wr(ct, 32'h2);
        fl(1'b1, 12'h010, 16'h0000, 2'h3, 1'b1);
        rd("status", st, 32'h0);
        fl(1'b1, 12'h400, 16'h0000, 2'h3, 1'b0);
        fr(12'h400, 16'hFFFF);
        fr(12'h010, 16'h5555);
        wr(ct, 32'h1);
        fl(1'b1, 12'hC00, 16'h0000, 2'h3, 1'b1);
        rd("status", st, 32'h0);
        fl(1'b1, 12'h010, 16'h0000, 2'h3, 1'b1);
        fr(12'h010, 16'hFFFF);
        wr(ct, 32'h1);
        fl(1'b1, 12'h400, 16'h0000, 2'h3, 1'b1);
        rude = 1'b1;
        fl(1'b0, 12'h400, 16'h0000, 2'h3, 1'b1);
        rude = 1'b0;
        rd("status", st, 32'h5);
        wait_idle();
        rd("status", st, 32'h4);
        wr(st, 32'h4);
        rd("status", st, 32'h0);
        end_sim();
    end
endmodule
